// ---- core/adcs_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "adcs_defines.svh"


module adcs_top
    import adcs_pkg::*;
#(
    parameter int unsigned WD_TIMEOUT_CYC = `ADCS_WD_PERIOD_MS * `ADCS_CLK_KHZ
) (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       ss_n,
    input  wire logic       serial_clock_pin,
    input  wire logic       mosi,
    output logic            miso,
    output logic            miso_oe_n,
    input  wire logic       pwm_gate_input,
    input  wire logic       watchdog_config_pin,
    input  wire logic       reg_overtemp_in,
    input  wire logic [2:0] switch_overtemp_in,
    input  wire logic       overvoltage_in,
    input  wire logic       undervoltage_in,
    input  wire logic       battery_fail_in,
    input  wire logic       lin_wake_in,
    input  wire logic       lin_fault_in,
    input  wire logic       wake_in_a,
    input  wire logic       wake_in_b,
    output logic            switch_a_out,
    output logic            switch_b_out,
    output logic            switch_c_out,
    output logic            irq_pulse,
    output logic            die_reset_n,
    output logic [1:0]      lin_speed_sel,
    output logic            lin_pullup_disconnect,
    output logic            low_power_stop,
    output logic            low_power_sleep
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic adcs_rise(input logic prev, input logic now);
        return now & ~prev;
    endfunction : adcs_rise

    function automatic logic adcs_active(input adcs_mode_type m);
        return (m == MODE_NREQ) || (m == MODE_RUN);
    endfunction : adcs_active

    localparam logic [23:0] WD_END  = 24'(WD_TIMEOUT_CYC - 1);
    localparam logic [23:0] WD_OPEN = 24'(WD_TIMEOUT_CYC / 2);

    adcs_pins_type  pins;
    adcs_state_type q;
    adcs_state_type d;

    assign pins = '{ss_n: ss_n, sclk: serial_clock_pin, mosi: mosi, pwm: pwm_gate_input,
                    wdcfg: watchdog_config_pin, reg_hot: reg_overtemp_in,
                    sw_hot: switch_overtemp_in, ov: overvoltage_in, uv: undervoltage_in,
                    battery_fail_flag: battery_fail_in, lin_wake: lin_wake_in,
                    lin_fault: lin_fault_in, wake_b: wake_in_b, wake_a: wake_in_a};

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        logic       act;
        logic       ss_fall;
        logic       ss_rise;
        logic       valid;
        logic       wd_clear;
        logic       wd_fail;
        logic       wake_chg;
        logic [6:0] rt;
        logic [6:0] ev;
        act      = 1'b0;
        ss_fall  = 1'b0;
        ss_rise  = 1'b0;
        valid    = 1'b0;
        wd_clear = 1'b0;
        wd_fail  = 1'b0;
        wake_chg = 1'b0;
        rt       = 7'h00;
        ev       = 7'h00;
        d        = q;

        // The first stage is read only by the second; edges use stage two.
        d.meta = pins;
        d.syn  = q.meta;
        d.old  = q.syn;

        act      = adcs_active(q.mode);
        ss_fall  = adcs_rise(~q.old.ss_n, ~q.syn.ss_n);
        ss_rise  = adcs_rise(q.old.ss_n, q.syn.ss_n);
        wake_chg = (q.syn.wake_a ^ q.old.wake_a) | (q.syn.wake_b ^ q.old.wake_b);

        // Real-time status; thermal and supply sensing is blind in low power.
        rt = {q.syn.lin_wake | q.syn.lin_fault, q.syn.ov & act, q.syn.uv & act,
              q.syn.reg_hot & act, (|q.syn.sw_hot) & act,
              q.syn.wake_b, q.syn.wake_a};

        // Event sources are rise edges, except wake_a and wake_b, which report both edges; the supply and thermal ones are masked outside the active modes.
        ev[6] = adcs_rise(q.old.lin_wake | q.old.lin_fault, q.syn.lin_wake | q.syn.lin_fault);
        ev[5] = act & adcs_rise(q.old.ov, q.syn.ov);
        ev[4] = act & adcs_rise(q.old.uv, q.syn.uv);
        ev[3] = act & adcs_rise(q.old.reg_hot, q.syn.reg_hot);
        ev[2] = act & adcs_rise(|q.old.sw_hot, |q.syn.sw_hot);
        ev[1] = (q.syn.wake_b ^ q.old.wake_b);
        ev[0] = (q.syn.wake_a ^ q.old.wake_a);

        // --------------------------------------------------------------------
        // Serial slave
        // --------------------------------------------------------------------
        if (ss_fall) begin
            d.bitcnt = 4'h0;
            d.tx     = q.src_flag ? {1'b1, q.src_bits} : {1'b0, rt};
            if (q.first_read) begin
                d.tx[`ADCS_STS_UV] = q.syn.battery_fail_flag;
            end
            d.src_flag   = 1'b0;
            d.src_bits   = 7'h00;
            d.first_read = 1'b0;
        end else if (!q.syn.ss_n) begin
            if (adcs_rise(q.syn.sclk, q.old.sclk)) begin
                d.rx = {q.rx[6:0], q.syn.mosi};
                if (q.bitcnt != 4'hf) begin
                    d.bitcnt = q.bitcnt + 4'h1;
                end
            end
            if (adcs_rise(q.old.sclk, q.syn.sclk) && (q.bitcnt != 4'h0)) begin
                d.tx = {q.tx[6:0], 1'b0};
            end
        end
        valid = ss_rise && (q.bitcnt == `ADCS_SPI_BITS);
        if (valid) begin
            d.ctrl = q.rx;
            if (q.rx[`ADCS_CTL_SW_A]) d.sw_latch[0] = 1'b0;
            if (q.rx[`ADCS_CTL_SW_B]) d.sw_latch[1] = 1'b0;
            if (q.rx[`ADCS_CTL_SW_C]) d.sw_latch[2] = 1'b0;
        end

        // --------------------------------------------------------------------
        // Thermal latches; a fresh fault beats a clearing write.
        // --------------------------------------------------------------------
        if (act) begin
            d.sw_latch = d.sw_latch | q.syn.sw_hot;
        end

        // --------------------------------------------------------------------
        // Source report and interrupt pulse
        // --------------------------------------------------------------------
        d.irq = |ev;
        if (|ev) begin
            d.src_flag = 1'b1;
            d.src_bits = d.src_bits | ev;
        end

        // --------------------------------------------------------------------
        // Operating modes and window watchdog
        // --------------------------------------------------------------------
        if (valid) begin
            unique case (q.rx[`ADCS_CTL_OP_HI:`ADCS_CTL_OP_LO])
                `ADCS_OP_SLEEP, `ADCS_OP_STOP: begin
                    if (q.rx[`ADCS_CTL_SPEED_HI:`ADCS_CTL_SPEED_LO] != `ADCS_SPEED_LP) begin
                        d.lp_pend = 1'b0;
                    end else if (q.lp_pend && (q.lp_byte == q.rx) && act) begin
                        d.lp_pend = 1'b0;
                        d.mode    = q.rx[`ADCS_CTL_OP_LO] ? MODE_STOP : MODE_SLEEP;
                    end else begin
                        d.lp_pend = 1'b1;
                        d.lp_byte = q.rx;
                    end
                end
                `ADCS_OP_WDCLR: begin
                    d.lp_pend = 1'b0;
                    wd_clear  = 1'b1;
                end
                `ADCS_OP_RUN: begin
                    d.lp_pend = 1'b0;
                    if (!q.syn.wdcfg && q.mode == MODE_NREQ) begin
                        d.mode = MODE_RUN;
                    end
                end
            endcase
        end else if (ss_rise) begin
            d.lp_pend = 1'b0;
        end

        if (!act || !q.syn.wdcfg) begin
            d.wd_cnt = 24'h00_0000;
            if (wd_clear && q.mode == MODE_NREQ) begin
                d.mode = MODE_RUN;
            end
        end else if (q.mode == MODE_NREQ) begin
            d.wd_cnt = q.wd_cnt + 24'h00_0001;
            if (wd_clear) begin
                d.mode   = MODE_RUN;
                d.wd_cnt = 24'h00_0000;
            end else if (q.wd_cnt >= WD_END) begin
                wd_fail = 1'b1;
            end
        end else begin
            d.wd_cnt = q.wd_cnt + 24'h00_0001;
            if (wd_clear) begin
                wd_fail  = (q.wd_cnt < WD_OPEN);
                d.wd_cnt = 24'h00_0000;
            end else if (q.wd_cnt >= WD_END) begin
                wd_fail = 1'b1;
            end
        end

        // Wake-up handling in low power.
        if (q.mode == MODE_STOP && (wake_chg || ev[6] || ss_rise)) begin
            d.mode = MODE_NREQ;
        end
        if (q.mode == MODE_SLEEP && (wake_chg || ev[6])) begin
            wd_fail = 1'b1;
        end

        if (q.mode == MODE_RESET) begin
            d.rst_cnt = q.rst_cnt - 8'h01;
            if (q.rst_cnt <= 8'h01) begin
                d.mode    = MODE_NREQ;
                d.rst_cnt = 8'h00;
            end
        end

        // Device reset keeps the pullup choice; only power-on clears it.
        if (wd_fail) begin
            d.mode       = MODE_RESET;
            d.rst_cnt    = `ADCS_RST_PULSE_CYC;
            d.ctrl       = `ADCS_CTL_RESET | (q.ctrl & 8'h20);
            d.wd_cnt     = 24'h00_0000;
            d.lp_pend    = 1'b0;
            d.sw_latch   = 3'h0;
            d.src_flag   = 1'b0;
            d.src_bits   = 7'h00;
            d.first_read = 1'b1;
        end

        // Output drivers, registered from the settled state.
        d.sw_out[0] = q.ctrl[`ADCS_CTL_SW_A] & q.syn.pwm & ~q.sw_latch[0] & act;
        d.sw_out[1] = q.ctrl[`ADCS_CTL_SW_B] & q.syn.pwm & ~q.sw_latch[1] & act;
        d.sw_out[2] = q.ctrl[`ADCS_CTL_SW_C] & ~q.sw_latch[2] & act;
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            // Sampling runs on through reset, so a level held across reset on any pin but ss_n,
            // which is forced high, does not look like a fresh event when reset is released.
            q            <= '0;
            q.meta       <= pins;
            q.syn        <= q.meta;
            q.old        <= q.syn;
            q.meta.ss_n  <= 1'b1;
            q.syn.ss_n   <= 1'b1;
            q.old.ss_n   <= 1'b1;
            q.ctrl       <= `ADCS_CTL_RESET;
            q.mode       <= MODE_NREQ;
            q.first_read <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign miso                  = q.tx[7];
    assign miso_oe_n             = q.syn.ss_n;
    assign switch_a_out          = q.sw_out[0];
    assign switch_b_out          = q.sw_out[1];
    assign switch_c_out          = q.sw_out[2];
    assign irq_pulse             = q.irq;
    assign die_reset_n           = (q.mode != MODE_RESET) && (q.mode != MODE_SLEEP);
    assign lin_speed_sel         = q.ctrl[`ADCS_CTL_SPEED_HI:`ADCS_CTL_SPEED_LO];
    assign lin_pullup_disconnect = q.ctrl[`ADCS_CTL_PULLUP];
    assign low_power_stop        = (q.mode == MODE_STOP);
    assign low_power_sleep       = (q.mode == MODE_SLEEP);

endmodule : adcs_top

`default_nettype wire

// ---- core/adcs_defines.svh ----
`ifndef ADCS_DEFINES_SVH
`define ADCS_DEFINES_SVH

// ----------------------------------------------------------------------------
// Control byte fields
// ----------------------------------------------------------------------------
`define ADCS_CTL_SPEED_HI   7
`define ADCS_CTL_SPEED_LO   6
`define ADCS_CTL_PULLUP     5
`define ADCS_CTL_SW_C       4
`define ADCS_CTL_SW_B       3
`define ADCS_CTL_SW_A       2
`define ADCS_CTL_OP_HI      1
`define ADCS_CTL_OP_LO      0
`define ADCS_CTL_RESET      8'h00

// ----------------------------------------------------------------------------
// Status byte fields
// ----------------------------------------------------------------------------
`define ADCS_STS_SRC        7
`define ADCS_STS_UV         4

// ----------------------------------------------------------------------------
// Operation select codes and SPI framing
// ----------------------------------------------------------------------------
`define ADCS_OP_SLEEP       2'h0
`define ADCS_OP_STOP        2'h1
`define ADCS_OP_WDCLR       2'h2
`define ADCS_OP_RUN         2'h3
`define ADCS_SPEED_LP       2'h3
`define ADCS_SPI_BITS       4'h8

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define ADCS_CLK_KHZ        100_000
`define ADCS_WD_PERIOD_MS   150
`define ADCS_RST_PULSE_CYC  8'h10

`endif

// ---- core/adcs_pkg.sv ----
package adcs_pkg;

    typedef enum logic [2:0] {
        MODE_RESET,
        MODE_NREQ,
        MODE_RUN,
        MODE_STOP,
        MODE_SLEEP
    } adcs_mode_type;

    typedef struct packed {
        logic       ss_n;
        logic       sclk;
        logic       mosi;
        logic       pwm;
        logic       wdcfg;
        logic       reg_hot;
        logic [2:0] sw_hot;
        logic       ov;
        logic       uv;
        logic       battery_fail_flag;
        logic       lin_wake;
        logic       lin_fault;
        logic       wake_b;
        logic       wake_a;
    } adcs_pins_type;

    typedef struct packed {
        adcs_pins_type meta;
        adcs_pins_type syn;
        adcs_pins_type old;
        logic [7:0]    ctrl;
        logic [7:0]    tx;
        logic [7:0]    rx;
        logic [3:0]    bitcnt;
        logic          lp_pend;
        logic [7:0]    lp_byte;
        adcs_mode_type mode;
        logic [23:0]   wd_cnt;
        logic [7:0]    rst_cnt;
        logic [2:0]    sw_latch;
        logic [2:0]    sw_out;
        logic          src_flag;
        logic [6:0]    src_bits;
        logic          first_read;
        logic          irq;
    } adcs_state_type;

endpackage : adcs_pkg

// ---- tb/adcs_top_props.sv ----
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------------
// Port checks for the control die
// ----------------------------------------------------------------------------
module adcs_top_props (
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic       ss_n,
    input wire logic       miso_oe_n,
    input wire logic       pwm_gate_input,
    input wire logic       reg_overtemp_in,
    input wire logic [2:0] switch_overtemp_in,
    input wire logic       switch_a_out,
    input wire logic       switch_b_out,
    input wire logic       switch_c_out,
    input wire logic       irq_pulse,
    input wire logic       die_reset_n,
    input wire logic [1:0] lin_speed_sel,
    input wire logic       lin_pullup_disconnect,
    input wire logic       low_power_stop,
    input wire logic       low_power_sleep
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // Six cycles cover the two-stage synchroniser plus the output register.
    sequence pwm_low_s; !pwm_gate_input [*6]; endsequence
    sequence ss_idle_s; ss_n [*6]; endsequence
    sequence ss_busy_s; !ss_n [*6]; endsequence
    sequence low_pwr_s; (low_power_stop || low_power_sleep) [*2]; endsequence

    a_pwm_gates_a: assert property (pwm_low_s |-> !switch_a_out)
        else $error("switch a on with pwm low");
    a_pwm_gates_b: assert property (pwm_low_s |-> !switch_b_out)
        else $error("switch b on with pwm low");
    a_hot_cuts_a: assert property (switch_overtemp_in[0] [*6] |-> !switch_a_out)
        else $error("switch a on while hot");
    a_hot_cuts_c: assert property (switch_overtemp_in[2] [*6] |-> !switch_c_out)
        else $error("switch c on while hot");
    a_low_pwr_off: assert property (low_pwr_s
        |-> !(switch_a_out || switch_b_out || switch_c_out))
        else $error("switch on in low power");
    a_miso_release: assert property (ss_idle_s |-> miso_oe_n)
        else $error("data out driven while deselected");
    a_miso_drive: assert property (die_reset_n throughout ss_busy_s |-> !miso_oe_n)
        else $error("data out not driven while selected");
    a_hot_irq: assert property ($rose(reg_overtemp_in) && die_reset_n && !low_power_stop
        && !low_power_sleep |-> ##[2:8] irq_pulse)
        else $error("no interrupt for regulator hot");
    a_reset_pulse: assert property ($fell(die_reset_n) |-> !die_reset_n [*8])
        else $error("die reset pulse too short");
    a_ctrl_reset: assert property ($rose(rst_n) |-> lin_speed_sel == 2'b00
        && !lin_pullup_disconnect)
        else $error("control not cleared by reset");
endmodule : adcs_top_props

bind adcs_top adcs_top_props u_props (
    .sys_clk, .rst_n, .ss_n, .miso_oe_n, .pwm_gate_input, .reg_overtemp_in,
    .switch_overtemp_in, .switch_a_out, .switch_b_out, .switch_c_out, .irq_pulse,
    .die_reset_n, .lin_speed_sel, .lin_pullup_disconnect, .low_power_stop, .low_power_sleep
);

`default_nettype wire

// ---- tb/adcs_spi_master.sv ----
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------------
// Master side of the serial link
// ----------------------------------------------------------------------------
module adcs_spi_master (
    output logic      ss_n,
    output logic      serial_clock_pin,
    output logic      mosi,
    input  wire logic miso,
    input  wire logic miso_oe_n
);
    // The clock stands low between frames, and the data line is inverted once
    // released so that a stale bit is never taken for a driven one.
    initial begin
        ss_n = 1'b1;
        serial_clock_pin = 1'b0;
        mosi = 1'b0;
    end

    task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
        rx = 8'h00;
        ss_n = 1'b0;
        #200;
        for (int i = 0; i < nb; i++) begin
            serial_clock_pin = 1'b1;
            mosi = tx[7 - (i % 8)];
            #62.5;
            serial_clock_pin = 1'b0;
            rx = {rx[6:0], miso_oe_n ? 1'bz : miso};
            #62.5;
        end
        ss_n = 1'b1;
        mosi = ~mosi;
        #60;
    endtask : xfer
endmodule : adcs_spi_master

`default_nettype wire

// ---- tb/tb_adcs_top.sv ----
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------------
// Bench
// ----------------------------------------------------------------------------
module tb_adcs_top;
    logic       sys_clk, rst_n, pwm_gate_input, watchdog_config_pin, reg_overtemp_in;
    logic       overvoltage_in, undervoltage_in, battery_fail_in, lin_wake_in;
    logic       lin_fault_in, wake_in_a, wake_in_b;
    logic [2:0] switch_overtemp_in;
    wire        ss_n, serial_clock_pin, mosi, miso, miso_oe_n, irq_pulse, die_reset_n;
    wire        switch_a_out, switch_b_out, switch_c_out, lin_pullup_disconnect;
    wire        low_power_stop, low_power_sleep;
    wire  [1:0] lin_speed_sel;
    wire  [7:0] sw_now = {5'h00, switch_c_out, switch_b_out, switch_a_out};
    wire  [7:0] lin_now = {5'h00, lin_speed_sel, lin_pullup_disconnect};
    logic [7:0] rd, b, r;
    int         num_errors, n_checks;

    adcs_top #(.WD_TIMEOUT_CYC(2000)) dut (.*);
    adcs_spi_master m (.*);

    always #5 sys_clk = ~sys_clk;

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic test_done;
        if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done

    task automatic xb(input logic [7:0] v);
        m.xfer(v, 8, rd);
        tick(6);
    endtask : xb

    function automatic logic [7:0] sw_exp(input logic [7:0] v, input logic p);
        return {5'h00, v[4], v[3] & p, v[2] & p};
    endfunction : sw_exp

    task automatic wait_for(input int sel, input logic lvl, input int lim);
        logic s;
        for (int i = 0; i <= lim; i++) begin
            s = sel == 0 ? irq_pulse : (sel == 1 ? die_reset_n : low_power_stop);
            if (s === lvl) return;
            tick(1);
        end
        num_errors++;
        test_done();
    endtask : wait_for

    initial begin
        {sys_clk, rst_n, watchdog_config_pin, reg_overtemp_in, switch_overtemp_in} = '0;
        {overvoltage_in, undervoltage_in, lin_wake_in, lin_fault_in, wake_in_a, wake_in_b} = '0;
        pwm_gate_input = 1'b1;
        battery_fail_in = 1'b1;
        num_errors = 0;
        n_checks = 0;
        r = 8'($urandom(49921));
        tick(3);
        rst_n = 1'b1;
        tick(6);
        chk(lin_now | sw_now, 8'h00);
        xb(8'h03);
        chk(8'(rd[4]), 8'h01);
        xb(8'h03);
        chk(8'(rd[4]), 8'h00);
        for (int i = 0; i < 8; i++) begin
            r = 8'($urandom);
            b = i == 0 ? 8'h7f : (i == 1 ? 8'h83 : {1'b0, r[6:2], 1'b1, r[0]});
            pwm_gate_input = r[7];
            xb(b);
            chk(lin_now, 8'(b[7:5]));
            chk(sw_now, sw_exp(b, pwm_gate_input));
            pwm_gate_input = ~pwm_gate_input;
            tick(6);
            chk(sw_now, sw_exp(b, pwm_gate_input));
        end
        for (int n = 7; n <= 9; n += 2) begin
            m.xfer(8'h5e, n, rd);
            tick(6);
            chk(lin_now, 8'(b[7:5]));
            chk(sw_now, sw_exp(b, pwm_gate_input));
        end
        pwm_gate_input = 1'b1;
        xb(8'h5f);
        switch_overtemp_in = 3'b101;
        wait_for(0, 1'b1, 40);
        tick(6);
        chk(sw_now, 8'h02);
        switch_overtemp_in = 3'b000;
        tick(8);
        chk(sw_now, 8'h02);
        xb(8'h5f);
        chk({6'h00, rd[7], rd[2]}, 8'h03);
        chk(sw_now, 8'h07);
        xb(8'h5f);
        chk({6'h00, rd[7], rd[2]}, 8'h00);
        reg_overtemp_in = 1'b1;
        wait_for(0, 1'b1, 40);
        xb(8'h5f);
        xb(8'h5f);
        chk({6'h00, rd[7], rd[3]}, 8'h01);
        reg_overtemp_in = 1'b0;
        xb(8'hdd);
        chk(8'(low_power_stop), 8'h00);
        xb(8'hdd);
        chk(8'(low_power_stop), 8'h01);
        chk(sw_now, 8'h00);
        reg_overtemp_in = 1'b1;
        switch_overtemp_in = 3'b010;
        repeat (30) begin
            tick(1);
            chk(8'(irq_pulse), 8'h00);
        end
        wake_in_a = 1'b1;
        wait_for(2, 1'b0, 40);
        {reg_overtemp_in, switch_overtemp_in} = '0;
        tick(20);
        chk(8'(die_reset_n), 8'h01);
        xb(8'hec);
        xb(8'hec);
        chk(8'(low_power_sleep), 8'h01);
        chk(sw_now, 8'h00);
        chk(lin_now, 8'h07);
        wake_in_b = 1'b1;
        wait_for(1, 1'b1, 40);
        chk(lin_now, 8'h01);
        xb(8'h03);
        chk(8'(rd[4]), 8'h01);
        watchdog_config_pin = 1'b1;
        rst_n = 1'b0;
        tick(3);
        rst_n = 1'b1;
        tick(6);
        xb(8'h02);
        chk(rd, 8'h13);
        tick(1200);
        chk(8'(die_reset_n), 8'h01);
        xb(8'h02);
        chk(8'(die_reset_n), 8'h01);
        m.xfer(8'h02, 8, rd);
        wait_for(1, 1'b0, 30);
        wait_for(1, 1'b1, 100);
        wait_for(1, 1'b0, 2300);
        test_done();
    end
endmodule : tb_adcs_top

`default_nettype wire
